// >>> rbt_far_end.sv
// Far-side logic model: pin controls and both bus sides
`timescale 1ns/100ps
module rbt_far_end (
    // Clock
    input wire logic                                               i_ref_clk,
    // Device drive towards each bus side
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] i_a_drive,
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] i_a_drive_oe_n,
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] i_b_drive,
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] i_b_drive_oe_n,
    // Pin controls
    output logic [rbt_pkg::SECTIONS-1:0]                           o_a_to_b_clock,
    output logic [rbt_pkg::SECTIONS-1:0]                           o_b_to_a_clock,
    output logic [rbt_pkg::SECTIONS-1:0]                           o_a_to_b_load_enable_n,
    output logic [rbt_pkg::SECTIONS-1:0]                           o_b_to_a_load_enable_n,
    output logic [rbt_pkg::SECTIONS-1:0]                           o_a_to_b_drive_enable_n,
    output logic [rbt_pkg::SECTIONS-1:0]                           o_b_to_a_drive_enable_n,
    // Wire levels of the bus sides
    output logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0]      o_a_side_bus_bit,
    output logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0]      o_b_side_bus_bit
);
    import rbt_pkg::*;
    // Lane state; lane is {section, direction}, even lanes carry A to B
    logic [LANES-1:0]             clk_reg = '0;
    logic [LANES-1:0]             le_n_reg = '1;
    logic [LANES-1:0]             de_n_reg = '1;
    logic [LANES-1:0][DATA_W-1:0] dat_reg = '0;

    // Pins and wire levels of each section
    for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
        assign o_a_to_b_clock[s] = clk_reg[2*s];
        assign o_b_to_a_clock[s] = clk_reg[2*s+1];
        assign o_a_to_b_load_enable_n[s] = le_n_reg[2*s];
        assign o_b_to_a_load_enable_n[s] = le_n_reg[2*s+1];
        assign o_a_to_b_drive_enable_n[s] = de_n_reg[2*s];
        assign o_b_to_a_drive_enable_n[s] = de_n_reg[2*s+1];
        // Far side lets go of a side while the device drives it, so no contention
        assign o_a_side_bus_bit[s] = (i_a_drive_oe_n[s] === 8'h00) ? i_a_drive[s] : dat_reg[2*s];
        assign o_b_side_bus_bit[s] = (i_b_drive_oe_n[s] === 8'h00) ? i_b_drive[s] : dat_reg[2*s+1];
    end

    // Load request; data and enable settle four cycles before the clock rise, enable held until four cycles after the fall
    task automatic load(input int l, input logic [DATA_W-1:0] d, input logic le_n);
        @(posedge i_ref_clk);
        dat_reg[l] <= d;
        le_n_reg[l] <= le_n;
        repeat (4) @(posedge i_ref_clk);
        clk_reg[l] <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        clk_reg[l] <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        le_n_reg[l] <= 1'b1;
    endtask

    // Drive enables for all lanes
    task automatic drive(input logic [LANES-1:0] de_n);
        @(posedge i_ref_clk);
        de_n_reg <= de_n;
    endtask
endmodule // rbt_far_end

// >>> rbt_fifo.sv
// Synchronous FIFO carrying captured loads to the storage registers
`timescale 1ns/100ps
module rbt_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = rbt_pkg::FIFO_DEPTH
) (
    // Clock and control
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_clk_en,
    // Fill side
    input  wire logic                     i_in_valid,
    output logic                          o_in_ready,
    input  wire logic [WIDTH-1:0]         i_in_data,
    // Drain side
    output logic                          o_out_valid,
    input  wire logic                     i_out_ready,
    output logic [WIDTH-1:0]              o_out_data,
    // Fill level
    output logic [$clog2(DEPTH):0]        o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LEVEL = DEPTH[AW:0];

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      level_reg;
    logic             push;
    logic             pop;

    // Flags come straight from the level count
    assign o_in_ready  = (level_reg != FULL_LEVEL);
    assign o_out_valid = (level_reg != '0);
    assign o_out_data  = mem_reg[rd_ptr_reg];
    assign o_level     = level_reg;
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // Storage, not reset since contents are qualified by the level
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en && push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
        end else if (i_clk_en) begin
            if (push) begin
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            end
            if (push && !pop) begin
                level_reg <= (AW+1)'(level_reg + 1'b1);
            end else if (pop && !push) begin
                level_reg <= (AW+1)'(level_reg - 1'b1);
            end
        end
    end
endmodule // rbt_fifo

// >>> rbt_pkg.sv
// Constants and types for the registered bidirectional transceiver
package rbt_pkg;
    localparam int DATA_W     = 8;
    localparam int SECTIONS   = 2;
    localparam int LANES      = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_W     = 4;

    // Lane index is {section, direction}; direction 0 is A to B
    localparam logic DIR_A_TO_B = 1'b0;
    localparam logic DIR_B_TO_A = 1'b1;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STORE  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PINS   = 4'hc;

    // Field positions
    localparam int CTRL_HOLD_BIT     = 0;
    localparam int STAT_LEVEL_LSB    = 0;
    localparam int STAT_OVERWR_BIT   = 8;
    localparam int STAT_FULL_BIT     = 9;

    // Reset values
    localparam logic       CTRL_HOLD_RST = 1'b0;
    localparam logic [7:0] DRIVE_OFF     = 8'hff;

    // One capture travelling through the FIFO
    typedef struct packed {
        logic              sec;
        logic              dir;
        logic [DATA_W-1:0] data;
    } rbt_load_t;

    // Pin levels of one lane, all from outside the clock domain
    typedef struct packed {
        logic              clock;
        logic              load_enable_n;
        logic              drive_enable_n;
        logic [DATA_W-1:0] bus_bit;
    } rbt_pin_t;

    localparam rbt_pin_t PIN_RST = '{clock: 1'b0, load_enable_n: 1'b1, drive_enable_n: 1'b1, bus_bit: 8'h00};
endpackage

// >>> rbt_top.sv
// Registered bidirectional transceiver: pin sampling, capture, storage, drivers, registers
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module rbt_top (
    // Clock, reset, clock enable
    input  wire logic                                        i_ref_clk,
    input  wire logic                                        i_rst_n,
    input  wire logic                                        i_clk_en,
    // Direction clocks and enables, one bit per section
    input  wire logic [rbt_pkg::SECTIONS-1:0]                i_a_to_b_clock,
    input  wire logic [rbt_pkg::SECTIONS-1:0]                i_b_to_a_clock,
    input  wire logic [rbt_pkg::SECTIONS-1:0]                i_a_to_b_load_enable_n,
    input  wire logic [rbt_pkg::SECTIONS-1:0]                i_b_to_a_load_enable_n,
    input  wire logic [rbt_pkg::SECTIONS-1:0]                i_a_to_b_drive_enable_n,
    input  wire logic [rbt_pkg::SECTIONS-1:0]                i_b_to_a_drive_enable_n,
    // A side bus pins
    input  wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] i_a_side_bus_bit,
    output logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0]      o_a_side_bus_bit,
    output logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0]      o_a_side_bus_oe_n,
    // B side bus pins
    input  wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] i_b_side_bus_bit,
    output logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0]      o_b_side_bus_bit,
    output logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0]      o_b_side_bus_oe_n,
    // Register port
    input  wire logic [rbt_pkg::ADDR_W-1:0]                  i_reg_addr,
    input  wire logic [31:0]                                 i_reg_wdata,
    input  wire logic                                        i_reg_wr,
    input  wire logic                                        i_reg_rd,
    output logic [31:0]                                      o_reg_rdata,
    // Capture path back-pressure
    output logic                                             o_fifo_ready
);
    import rbt_pkg::*;

    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    // Synchroniser stages and accepted levels, one per lane
    rbt_pin_t         pin_raw [LANES];
    rbt_pin_t         sync1_reg [LANES];
    rbt_pin_t         sync2_reg [LANES];
    rbt_pin_t         sync3_reg [LANES];
    rbt_pin_t         filt_reg [LANES];
    logic [LANES-1:0] clk_prev_reg;
    logic [LANES-1:0] load_evt;

    // Pending captures waiting for the FIFO
    logic [LANES-1:0]  pend_vld_reg;
    logic [DATA_W-1:0] pend_data_reg [LANES];
    logic [1:0]        pend_sel;
    logic              pend_any;
    rbt_load_t         push_load;
    logic              fifo_in_ready;

    // Drain side
    rbt_load_t         pop_load;
    logic              fifo_out_valid;
    logic              fifo_pop;
    logic [LVL_W-1:0]  fifo_level;

    // Direction storage, deliberately without reset
    logic [DATA_W-1:0] store_reg [LANES];

    // Software visible state, the ready output flop and the drive enables
    logic              hold_reg;
    logic              overwr_reg;
    logic [31:0]       rdata_reg;
    logic              fifo_ready_reg;
    logic [SECTIONS-1:0][DATA_W-1:0] a_oe_n_reg;
    logic [SECTIONS-1:0][DATA_W-1:0] b_oe_n_reg;

    // Lowest pending lane wins; pins are far slower than the clock so no starvation
    function automatic logic [1:0] first_lane(input logic [LANES-1:0] vld);
        logic [1:0] idx;
        idx = 2'd0;
        for (int i = LANES - 1; i >= 0; i--) begin
            if (vld[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // Lane number from section and direction
    function automatic logic [1:0] lane_of(input logic sec, input logic dir);
        return {sec, dir};
    endfunction

    // Gather pins per lane; A to B takes the A bus, B to A the B bus
    always_comb begin
        for (int s = 0; s < SECTIONS; s++) begin
            pin_raw[lane_of(s[0], DIR_A_TO_B)] = '{clock: i_a_to_b_clock[s],
                load_enable_n: i_a_to_b_load_enable_n[s],
                drive_enable_n: i_a_to_b_drive_enable_n[s], bus_bit: i_a_side_bus_bit[s]};
            pin_raw[lane_of(s[0], DIR_B_TO_A)] = '{clock: i_b_to_a_clock[s],
                load_enable_n: i_b_to_a_load_enable_n[s],
                drive_enable_n: i_b_to_a_drive_enable_n[s], bus_bit: i_b_side_bus_bit[s]};
        end
    end

    // Three-stage sampling; a bit is accepted once stages two and three agree
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            for (int l = 0; l < LANES; l++) begin
                sync1_reg[l] <= PIN_RST;
                sync2_reg[l] <= PIN_RST;
                sync3_reg[l] <= PIN_RST;
                filt_reg[l]  <= PIN_RST;
            end
            clk_prev_reg <= '0;
        end else if (i_clk_en) begin
            for (int l = 0; l < LANES; l++) begin
                sync1_reg[l] <= pin_raw[l];
                sync2_reg[l] <= sync1_reg[l];
                sync3_reg[l] <= sync2_reg[l];
                filt_reg[l]  <= (filt_reg[l] & (sync2_reg[l] ^ sync3_reg[l]))
                              | (sync2_reg[l] & ~(sync2_reg[l] ^ sync3_reg[l]));
                clk_prev_reg[l] <= filt_reg[l].clock;
            end
        end
    end

    // Rising clock with load enable low is a capture
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            load_evt[l] = filt_reg[l].clock & ~clk_prev_reg[l]
                        & ~filt_reg[l].load_enable_n;
        end
    end

    // Arbitration of pending captures onto the FIFO
    assign pend_any  = |pend_vld_reg;
    assign pend_sel  = first_lane(pend_vld_reg);
    assign push_load = '{sec: pend_sel[1], dir: pend_sel[0], data: pend_data_reg[pend_sel]};

    // Pending slot per lane; a new capture beats the clear of a push
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pend_vld_reg <= '0;
        end else if (i_clk_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (load_evt[l]) begin
                    pend_vld_reg[l] <= 1'b1;
                end else if (pend_any && fifo_in_ready && pend_sel == 2'(l)) begin
                    pend_vld_reg[l] <= 1'b0;
                end
            end
        end
    end

    // Captured bus value, taken unchanged
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (load_evt[l]) begin
                    pend_data_reg[l] <= filt_reg[l].bus_bit;
                end
            end
        end
    end

    // Holds captures while software freezes the storage
    rbt_fifo #(
        .WIDTH ($bits(rbt_load_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_clk_en    (i_clk_en),
        .i_in_valid  (pend_any),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_load),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (~hold_reg),
        .o_out_data  (pop_load),
        .o_level     (fifo_level)
    );

    assign fifo_pop = fifo_out_valid & ~hold_reg;

    // Each lane owns its own register; loads land whatever the drive enables say
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en && fifo_pop) begin
            store_reg[lane_of(pop_load.sec, pop_load.dir)] <= pop_load.data;
        end
    end

    // Drive enables; high means pins released so the far side may drive
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            a_oe_n_reg <= {SECTIONS{DRIVE_OFF}};
            b_oe_n_reg <= {SECTIONS{DRIVE_OFF}};
        end else if (i_clk_en) begin
            for (int s = 0; s < SECTIONS; s++) begin
                b_oe_n_reg[s] <= {DATA_W{filt_reg[lane_of(s[0], DIR_A_TO_B)].drive_enable_n}};
                a_oe_n_reg[s] <= {DATA_W{filt_reg[lane_of(s[0], DIR_B_TO_A)].drive_enable_n}};
            end
        end
    end

    // Bus outputs come straight from storage
    always_comb begin
        for (int s = 0; s < SECTIONS; s++) begin
            o_b_side_bus_bit[s] = store_reg[lane_of(s[0], DIR_A_TO_B)];
            o_a_side_bus_bit[s] = store_reg[lane_of(s[0], DIR_B_TO_A)];
        end
    end
    assign o_a_side_bus_oe_n = a_oe_n_reg;
    assign o_b_side_bus_oe_n = b_oe_n_reg;

    // Hold bit stalls draining, so the FIFO really fills
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            hold_reg <= CTRL_HOLD_RST;
        end else if (i_clk_en && i_reg_wr && i_reg_addr == OFS_CTRL) begin
            hold_reg <= i_reg_wdata[CTRL_HOLD_BIT];
        end
    end

    // Sticky overwrite: a capture onto a still pending slot; set beats clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            overwr_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (|(load_evt & pend_vld_reg)) begin
                overwr_reg <= 1'b1;
            end else if (i_reg_wr && i_reg_addr == OFS_STATUS && i_reg_wdata[STAT_OVERWR_BIT]) begin
                overwr_reg <= 1'b0;
            end
        end
    end

    // Ready seen at the port one cycle after the FIFO state
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            fifo_ready_reg <= 1'b1;
        end else if (i_clk_en) begin
            fifo_ready_reg <= fifo_in_ready;
        end
    end
    assign o_fifo_ready = fifo_ready_reg;

    // Read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_clk_en) begin
            rdata_reg <= 32'h0000_0000;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    OFS_CTRL: begin
                        rdata_reg[CTRL_HOLD_BIT] <= hold_reg;
                    end
                    OFS_STATUS: begin
                        rdata_reg[STAT_LEVEL_LSB +: LVL_W] <= fifo_level;
                        rdata_reg[STAT_OVERWR_BIT]         <= overwr_reg;
                        rdata_reg[STAT_FULL_BIT]           <= ~fifo_in_ready;
                    end
                    OFS_STORE: begin
                        rdata_reg <= {store_reg[3], store_reg[2], store_reg[1], store_reg[0]};
                    end
                    OFS_PINS: begin
                        for (int l = 0; l < LANES; l++) begin
                            rdata_reg[l*4 +: 3] <= {filt_reg[l].drive_enable_n,
                                                    filt_reg[l].load_enable_n, filt_reg[l].clock};
                        end
                    end
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
    assign o_reg_rdata = rdata_reg;
endmodule // rbt_top

// >>> rbt_top_assertions.sv
// Checker watching the transceiver's ports
`timescale 1ns/100ps
module rbt_top_assertions (
    // Clock and reset
    input wire logic                                               i_ref_clk,
    input wire logic                                               i_rst_n,
    // Pin controls
    input wire logic [rbt_pkg::SECTIONS-1:0]                       i_a_to_b_load_enable_n,
    input wire logic [rbt_pkg::SECTIONS-1:0]                       i_b_to_a_load_enable_n,
    input wire logic [rbt_pkg::SECTIONS-1:0]                       i_a_to_b_drive_enable_n,
    input wire logic [rbt_pkg::SECTIONS-1:0]                       i_b_to_a_drive_enable_n,
    // Bus sides
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] o_a_side_bus_bit,
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] o_a_side_bus_oe_n,
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] o_b_side_bus_bit,
    input wire logic [rbt_pkg::SECTIONS-1:0][rbt_pkg::DATA_W-1:0] o_b_side_bus_oe_n,
    // Register port
    input wire logic [rbt_pkg::ADDR_W-1:0]                         i_reg_addr,
    input wire logic                                               i_reg_wr,
    input wire logic                                               i_reg_rd,
    input wire logic [31:0]                                        o_reg_rdata,
    input wire logic                                               o_fifo_ready
);
    import rbt_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // Quiet span: no load request, no register write, so nothing can still be in flight
    logic [5:0] quiet_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_reg_wr || !(&{i_a_to_b_load_enable_n, i_b_to_a_load_enable_n})) begin
            quiet_reg <= 6'h00;
        end else if (quiet_reg != 6'h28) begin
            quiet_reg <= quiet_reg + 6'h01;
        end
    end

    // Drive enables held long enough to pass the pin sampling
    sequence s_ab_on; (i_a_to_b_drive_enable_n == 2'b00) [*8]; endsequence
    sequence s_ab_off; (i_a_to_b_drive_enable_n == 2'b11) [*8]; endsequence
    sequence s_ba_on; (i_b_to_a_drive_enable_n == 2'b00) [*8]; endsequence
    sequence s_ba_off; (i_b_to_a_drive_enable_n == 2'b11) [*8]; endsequence

    property p_ab_on; s_ab_on |-> o_b_side_bus_oe_n == '0; endproperty
    property p_ab_off; s_ab_off |-> o_b_side_bus_oe_n == '1; endproperty
    property p_ba_on; s_ba_on |-> o_a_side_bus_oe_n == '0; endproperty
    property p_ba_off; s_ba_off |-> o_a_side_bus_oe_n == '1; endproperty
    property p_reset_off;
        $rose(i_rst_n) |-> o_a_side_bus_oe_n == '1 && o_b_side_bus_oe_n == '1 && o_fifo_ready;
    endproperty
    property p_hold_ab; quiet_reg == 6'h28 |-> $stable(o_b_side_bus_bit); endproperty
    property p_hold_ba; quiet_reg == 6'h28 |-> $stable(o_a_side_bus_bit); endproperty
    property p_store_read;
        i_reg_rd && i_reg_addr == OFS_STORE |=> o_reg_rdata ==
            $past({o_a_side_bus_bit[1], o_b_side_bus_bit[1], o_a_side_bus_bit[0], o_b_side_bus_bit[0]});
    endproperty

    a_ab_on: assert property (p_ab_on) else $error("B side drivers stayed off");
    a_ab_off: assert property (p_ab_off) else $error("B side drivers stayed on");
    a_ba_on: assert property (p_ba_on) else $error("A side drivers stayed off");
    a_ba_off: assert property (p_ba_off) else $error("A side drivers stayed on");
    a_reset_off: assert property (p_reset_off) else $error("drivers not off after reset");
    a_hold_ab: assert property (p_hold_ab) else $error("A to B storage moved unloaded");
    a_hold_ba: assert property (p_hold_ba) else $error("B to A storage moved unloaded");
    a_store_read: assert property (p_store_read) else $error("storage readback differs");
endmodule // rbt_top_assertions

bind rbt_top rbt_top_assertions rbt_top_assertions_inst (
    .i_ref_clk, .i_rst_n, .i_a_to_b_load_enable_n, .i_b_to_a_load_enable_n,
    .i_a_to_b_drive_enable_n, .i_b_to_a_drive_enable_n, .o_a_side_bus_bit, .o_a_side_bus_oe_n,
    .o_b_side_bus_bit, .o_b_side_bus_oe_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_fifo_ready
);

// >>> rbt_top_tb.sv
// Self-checking bench for the registered transceiver
`timescale 1ns/100ps
module rbt_top_tb;
    import rbt_pkg::*;
    logic                            i_ref_clk = 1'b0;
    logic                            i_rst_n = 1'b0;
    logic [ADDR_W-1:0]               reg_addr = '0;
    logic [31:0]                     reg_wdata = '0;
    logic                            reg_wr = 1'b0;
    logic                            reg_rd = 1'b0;
    logic [31:0]                     reg_rdata;
    logic [31:0]                     rdv;
    logic                            fifo_ready;
    logic [SECTIONS-1:0]             ab_clk, ba_clk, ab_le_n, ba_le_n, ab_de_n, ba_de_n;
    logic [SECTIONS-1:0][DATA_W-1:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
    logic [DATA_W-1:0]               exp_q [LANES];
    int                              bad_count = 0;
    int                              tests_run = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    rbt_top rbt_top_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
        .i_a_to_b_clock(ab_clk), .i_b_to_a_clock(ba_clk), .i_a_to_b_load_enable_n(ab_le_n),
        .i_b_to_a_load_enable_n(ba_le_n), .i_a_to_b_drive_enable_n(ab_de_n), .i_b_to_a_drive_enable_n(ba_de_n),
        .i_a_side_bus_bit(a_in), .o_a_side_bus_bit(a_out), .o_a_side_bus_oe_n(a_oe_n),
        .i_b_side_bus_bit(b_in), .o_b_side_bus_bit(b_out), .o_b_side_bus_oe_n(b_oe_n),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .o_fifo_ready(fifo_ready));

    rbt_far_end rbt_far_end_inst (.i_ref_clk(i_ref_clk), .i_a_drive(a_out), .i_a_drive_oe_n(a_oe_n),
        .i_b_drive(b_out), .i_b_drive_oe_n(b_oe_n), .o_a_to_b_clock(ab_clk), .o_b_to_a_clock(ba_clk),
        .o_a_to_b_load_enable_n(ab_le_n), .o_b_to_a_load_enable_n(ba_le_n), .o_a_to_b_drive_enable_n(ab_de_n),
        .o_b_to_a_drive_enable_n(ba_de_n), .o_a_side_bus_bit(a_in), .o_b_side_bus_bit(b_in));

    // Expected status word from fill level and overwrite flag
    function automatic logic [31:0] status_of(input logic [4:0] lvl, input logic ow);
        status_of = '0;
        status_of[4:0] = lvl;
        status_of[STAT_OVERWR_BIT] = ow;
        status_of[STAT_FULL_BIT] = (lvl == FIFO_DEPTH);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge i_ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge i_ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Storage of a lane, compared once the capture pipeline has drained
    task automatic lane_check(input int l);
        repeat (10) @(posedge i_ref_clk);
        #1 check({24'h0, l[0] ? a_out[l/2] : b_out[l/2]}, {24'h0, exp_q[l]});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(22663));
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        settle(1);
        check({a_oe_n, b_oe_n}, 32'hffff_ffff);
        check({31'h0, fifo_ready}, 32'h1);
        rd(OFS_STATUS, rdv);
        check(rdv, status_of(5'h00, 1'b0));
        rd(OFS_PINS, rdv);
        check(rdv, 32'h0000_6666);
        $display("reset test done");
        // All zeros, all ones, then random, on every lane
        for (int k = 0; k < 3; k++) begin
            for (int l = 0; l < LANES; l++) begin
                exp_q[l] = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
                rbt_far_end_inst.load(l, exp_q[l], 1'b0);
                lane_check(l);
            end
        end
        rd(OFS_STORE, rdv);
        check(rdv, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
        rd(4'h2, rdv);
        check(rdv, 32'h0);
        // Clock edges with load enable high must not load
        for (int l = 0; l < LANES; l++) begin
            rbt_far_end_inst.load(l, ~exp_q[l], 1'b1);
            lane_check(l);
        end
        $display("load test done");
        rbt_far_end_inst.drive(4'h0);
        settle(10);
        check({a_oe_n, b_oe_n}, 32'h0);
        // A side now carries the device's own B to A value, so that is what loads
        exp_q[0] = exp_q[1];
        rbt_far_end_inst.load(0, 8'($urandom), 1'b0);
        lane_check(0);
        rbt_far_end_inst.drive(4'hf);
        settle(10);
        check({a_oe_n, b_oe_n}, 32'hffff_ffff);
        exp_q[2] = 8'($urandom);
        rbt_far_end_inst.load(2, exp_q[2], 1'b0);
        lane_check(2);
        $display("drive test done");
        // Stall the drain, fill the buffer, overrun the pending slot, then drain
        wr(OFS_CTRL, 32'h1);
        for (int n = 0; n < 18; n++) begin
            exp_q[0] = 8'($urandom);
            rbt_far_end_inst.load(0, exp_q[0], 1'b0);
            if (n == 16) begin
                settle(4);
                check({31'h0, fifo_ready}, 32'h0);
                rd(OFS_STATUS, rdv);
                check(rdv, status_of(5'h10, 1'b0));
            end
        end
        settle(4);
        rd(OFS_STATUS, rdv);
        check(rdv, status_of(5'h10, 1'b1));
        wr(OFS_STATUS, 32'h100);
        rd(OFS_STATUS, rdv);
        check(rdv, status_of(5'h10, 1'b0));
        wr(OFS_CTRL, 32'h0);
        settle(40);
        check({31'h0, fifo_ready}, 32'h1);
        rd(OFS_STATUS, rdv);
        check(rdv, status_of(5'h00, 1'b0));
        lane_check(0);
        $display("buffer test done");
        test_done();
    end

    // Watchdog well beyond the expected run of about eight hundred cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        bad_count++;
        test_done();
    end
endmodule // rbt_top_tb
